// >>> ufi_pkg.sv
`default_nettype none
// Shared constants and carriers of the USB function interrupt block
package ufi_pkg;

  // Wishbone widths
  localparam int unsigned WB_AW = 8;
  localparam int unsigned WB_DW = 32;
  localparam int unsigned IDX_W = 6;

  // Register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_IN_FLAGS = 6'h02;
  localparam logic [IDX_W-1:0] IDX_OUT_FLAGS = 6'h04;
  localparam logic [IDX_W-1:0] IDX_CM_FLAGS = 6'h06;
  localparam logic [IDX_W-1:0] IDX_IN_EN = 6'h07;
  localparam logic [IDX_W-1:0] IDX_OUT_EN = 6'h09;
  localparam logic [IDX_W-1:0] IDX_CM_EN = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_FRAME_LO = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_FRAME_HI = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 6'h10;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h11;

  // Field positions in the flag and enable registers
  localparam int unsigned BIT_EP0 = 0;
  localparam int unsigned BIT_IN1 = 1;
  localparam int unsigned BIT_OUT_ENDPOINT_ONE_FLAG = 1;
  localparam int unsigned BIT_SOF = 3;
  localparam int unsigned BIT_RST = 2;
  localparam int unsigned BIT_RSU = 1;
  localparam int unsigned BIT_SUS = 0;

  // Implemented bits of each register, and the common enables set by bus reset
  localparam logic [7:0] IN_MASK = 8'h03;
  localparam logic [7:0] OUT_MASK = 8'h02;
  localparam logic [7:0] CM_MASK = 8'h0F;
  localparam logic [7:0] CM_BUS_RST_EN = 8'h0E;
  localparam logic [7:0] CTRL_MASK = 8'h03;

  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] IN_EN_RST = 8'h03;
  localparam logic [7:0] OUT_EN_RST = 8'h02;
  localparam logic [7:0] CM_EN_RST = 8'h06;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [10:0] FRAME_RST = 11'h000;

  // Control and status fields
  localparam int unsigned CTRL_SUSPEND_DETECT_ENABLE = 0;
  localparam int unsigned CTRL_SYSEN = 1;
  localparam int unsigned STAT_SUSPEND = 0;
  localparam int unsigned STAT_PENDING = 1;
  localparam int unsigned STAT_ARMED = 2;

  // Frame timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned FRAME_PERIOD_NS = 1000000;
  localparam int unsigned FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned FCNT_W = 18;

  // Event strobes from the serial engine, one cycle each
  typedef struct packed {
    logic ctrl_ep;
    logic in_ep1;
    logic out_ep1;
    logic sof_valid;
    logic bus_reset;
    logic resume;
    logic suspend;
  } ufi_evt_t;

endpackage
`default_nettype wire

// >>> ufi_regs.sv
// Overview of operation
// [RL1] Frame number low byte read at 0x0C
// [RL2] Frame bits 10..8 at 0x0D, rest zero
// [RL3] Any enabled set flag raises interrupt request
// [RL4] Reading flag register returns then clears flags
// [RL5] Software writes never change flag bits
// [RL6] IN flags: endpoint one bit1, control bit0
// [RL7] OUT flags: endpoint one in bit1 only
// [RL8] Frame flag on token or missed token
// [RL9] Bus reset sets reset flag bit2
// [RL10] Resume flag only while in suspend mode
// [RL11] Suspend flag only with suspend detection enabled
// [RL12] Common flags at 0x06, upper nibble zero
// [RL13] IN enable at 0x07, resets to 03
// [RL14] OUT enable at 0x09, resets to 02
// [RL15] Request passes only with system enable
// [RL16] Common enable at 0x0B, resets to 06
// [RL17] Bus reset enables sources, clears flags
// [RL18] Latch frame number; synthesize missing frame
// [RL19] Event during read keeps flag set
`timescale 1ns/1ns
`default_nettype none
module ufi_regs #(
  parameter int unsigned FRAME_CYCLES_P = ufi_pkg::FRAME_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ufi_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ufi_pkg::WB_DW-1:0] wb_dat_i,
  output logic [ufi_pkg::WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial engine events
  input wire ufi_pkg::ufi_evt_t evt_i,
  input wire logic [10:0] frame_num_i,
  // Processor side
  output logic usb_irq_o,
  output logic suspend_mode_o
);
  import ufi_pkg::*;

  // Bus decode
  logic [IDX_W-1:0] idx;
  logic req;
  logic rd_req;
  logic wr_req;
  logic ack_q;
  logic [WB_DW-1:0] rdata_q;
  logic [7:0] rdata;

  // Flag and enable registers
  logic [7:0] in_flags_q;
  logic [7:0] out_flags_q;
  logic [7:0] cm_flags_q;
  logic [7:0] in_en_q;
  logic [7:0] out_en_q;
  logic [7:0] cm_en_q;
  logic [7:0] ctrl_q;
  logic [7:0] in_set;
  logic [7:0] out_set;
  logic [7:0] cm_set;
  logic [7:0] in_flags_d;
  logic [7:0] out_flags_d;
  logic [7:0] cm_flags_d;

  // Frame state
  logic [10:0] frame_q;
  logic [FCNT_W-1:0] fcnt_q;
  logic armed_q;
  logic sof_synth;
  logic suspend_q;
  logic irq_q;
  logic pending;

  // A request is served once; ack drops the cycle after it rises
  assign idx = wb_adr_i[IDX_W+1:2];
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign rd_req = req && !wb_we_i;
  assign wr_req = req && wb_we_i && wb_sel_i[0];

  // Missing frame token is synthesized one period after the last
  assign sof_synth = armed_q && !evt_i.sof_valid &&
                     (fcnt_q == FCNT_W'(FRAME_CYCLES_P - 1)); // [RL18] [RL8]

  // Hardware set vectors for each flag register
  always_comb begin
    in_set = '0;
    out_set = '0;
    cm_set = '0;
    in_set[BIT_IN1] = evt_i.in_ep1; // [RL6]
    in_set[BIT_EP0] = evt_i.ctrl_ep; // [RL6]
    out_set[BIT_OUT_ENDPOINT_ONE_FLAG] = evt_i.out_ep1; // [RL7]
    cm_set[BIT_SOF] = evt_i.sof_valid || sof_synth; // [RL8]
    cm_set[BIT_RST] = evt_i.bus_reset; // [RL9]
    cm_set[BIT_RSU] = evt_i.resume && suspend_q; // [RL10]
    cm_set[BIT_SUS] = evt_i.suspend && ctrl_q[CTRL_SUSPEND_DETECT_ENABLE]; // [RL11]
  end

  // Next flag values: reads and bus reset clear, events set and win
  always_comb begin
    in_flags_d = in_flags_q;
    out_flags_d = out_flags_q;
    cm_flags_d = cm_flags_q;
    if ((rd_req && idx == IDX_IN_FLAGS) || evt_i.bus_reset) begin
      in_flags_d = FLAGS_RST; // [RL4] [RL17]
    end
    if ((rd_req && idx == IDX_OUT_FLAGS) || evt_i.bus_reset) begin
      out_flags_d = FLAGS_RST; // [RL4] [RL17]
    end
    if ((rd_req && idx == IDX_CM_FLAGS) || evt_i.bus_reset) begin
      cm_flags_d = FLAGS_RST; // [RL4] [RL17]
    end
    // Set after clear so a coincident event survives
    in_flags_d = (in_flags_d | in_set) & IN_MASK; // [RL19] [RL6]
    out_flags_d = (out_flags_d | out_set) & OUT_MASK; // [RL19] [RL7]
    cm_flags_d = (cm_flags_d | cm_set) & CM_MASK; // [RL19] [RL12]
  end

  // Flag registers; bus writes do not reach them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_flags_q <= FLAGS_RST;
      out_flags_q <= FLAGS_RST;
      cm_flags_q <= FLAGS_RST;
    end else begin
      in_flags_q <= in_flags_d; // [RL5]
      out_flags_q <= out_flags_d; // [RL5]
      cm_flags_q <= cm_flags_d; // [RL5]
    end
  end

  // Enable registers; bus reset overrides a coincident write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_en_q <= IN_EN_RST; // [RL13]
      out_en_q <= OUT_EN_RST; // [RL14]
      cm_en_q <= CM_EN_RST; // [RL16]
    end else if (evt_i.bus_reset) begin
      // All sources on except suspend, which keeps its setting
      in_en_q <= IN_MASK; // [RL17]
      out_en_q <= OUT_MASK; // [RL17]
      cm_en_q <= cm_en_q | CM_BUS_RST_EN; // [RL17]
    end else if (wr_req) begin
      // Unused bits are dropped on write
      if (idx == IDX_IN_EN) begin
        in_en_q <= wb_dat_i[7:0] & IN_MASK; // [RL13]
      end
      if (idx == IDX_OUT_EN) begin
        out_en_q <= wb_dat_i[7:0] & OUT_MASK; // [RL14]
      end
      if (idx == IDX_CM_EN) begin
        cm_en_q <= wb_dat_i[7:0] & CM_MASK; // [RL16]
      end
    end
  end

  // Control register: suspend detection and system interrupt enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_req && idx == IDX_CONTROL) begin
      ctrl_q <= wb_dat_i[7:0] & CTRL_MASK;
    end
  end

  // Suspend mode: entered on detected suspend, left on resume or reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      suspend_q <= 1'b0;
    end else if (evt_i.resume || evt_i.bus_reset) begin
      suspend_q <= 1'b0;
    end else if (evt_i.suspend && ctrl_q[CTRL_SUSPEND_DETECT_ENABLE]) begin
      suspend_q <= 1'b1; // [RL11]
    end
  end

  // Frame number captured from each valid token
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_q <= FRAME_RST;
    end else if (evt_i.sof_valid) begin
      frame_q <= frame_num_i; // [RL18]
    end
  end

  // Frame period counter, armed by the first real token
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fcnt_q <= '0;
      armed_q <= 1'b0;
    end else if (evt_i.bus_reset) begin
      // Frame timing restarts after a bus reset
      fcnt_q <= '0;
      armed_q <= 1'b0;
    end else if (evt_i.sof_valid || sof_synth) begin
      fcnt_q <= '0; // [RL18]
      armed_q <= 1'b1;
    end else if (armed_q) begin
      fcnt_q <= fcnt_q + 1'b1;
    end
  end

  // Combined request from enabled flags
  assign pending = |((in_flags_q & in_en_q) | (out_flags_q & out_en_q) |
                     (cm_flags_q & cm_en_q)); // [RL3]

  // Interrupt output gated by the system level enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= pending && ctrl_q[CTRL_SYSEN]; // [RL3] [RL15]
    end
  end

  // Read multiplexer; unmapped indexes read zero
  always_comb begin
    rdata = '0;
    unique case (idx)
      IDX_IN_FLAGS: rdata = in_flags_q; // [RL6]
      IDX_OUT_FLAGS: rdata = out_flags_q; // [RL7]
      IDX_CM_FLAGS: rdata = cm_flags_q; // [RL12]
      IDX_IN_EN: rdata = in_en_q;
      IDX_OUT_EN: rdata = out_en_q;
      IDX_CM_EN: rdata = cm_en_q;
      IDX_FRAME_LO: rdata = frame_q[7:0]; // [RL1]
      IDX_FRAME_HI: rdata = {5'h00, frame_q[10:8]}; // [RL2]
      IDX_CONTROL: rdata = ctrl_q;
      IDX_STATUS: begin
        rdata[STAT_SUSPEND] = suspend_q;
        rdata[STAT_PENDING] = pending;
        rdata[STAT_ARMED] = armed_q;
      end
      default: rdata = '0;
    endcase
  end

  // Bus answer one cycle after the request, data captured with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= req;
      if (rd_req) begin
        rdata_q <= {24'h000000, rdata}; // [RL4]
      end
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign usb_irq_o = irq_q;
  assign suspend_mode_o = suspend_q;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A write request to the IN flag register with no IN event or bus reset alongside
  sequence s_quiet_flag_write;
    wr_req && (idx == IDX_IN_FLAGS) && !evt_i.ctrl_ep && !evt_i.in_ep1 &&
      !evt_i.bus_reset;
  endsequence

  // A read of the common flags with no event alongside
  sequence s_quiet_cm_read;
    rd_req && (idx == IDX_CM_FLAGS) && (cm_set == 8'h00) && !evt_i.bus_reset;
  endsequence

  // A read of the IN flags with no event alongside
  sequence s_quiet_in_read;
    rd_req && (idx == IDX_IN_FLAGS) && (in_set == 8'h00) && !evt_i.bus_reset;
  endsequence

  // A read of the OUT flags with no event alongside
  sequence s_quiet_out_read;
    rd_req && (idx == IDX_OUT_FLAGS) && (out_set == 8'h00) && !evt_i.bus_reset;
  endsequence

  a_ack_single_cycle: assert property (ack_q |=> !ack_q)
    else $error("ack held longer than one cycle");

  a_read_clears_cm: assert property (s_quiet_cm_read |=> cm_flags_q == 8'h00) // [RL4]
    else $error("common flags not cleared by read");

  a_read_returns_cm: assert property ( // [RL4]
    s_quiet_cm_read |=> wb_dat_o[7:0] == $past(cm_flags_q))
    else $error("read data differs from flags before clear");

  a_write_no_effect: assert property (s_quiet_flag_write |=> $stable(in_flags_q)) // [RL5]
    else $error("write changed flag register");

  a_event_wins_read: assert property ( // [RL19]
    rd_req && idx == IDX_IN_FLAGS && evt_i.ctrl_ep |=> in_flags_q[BIT_EP0] ##1 !ack_q)
    else $error("event lost during flag read");

  a_irq_follows: assert property (pending && ctrl_q[CTRL_SYSEN] |=> usb_irq_o) // [RL3]
    else $error("interrupt missing for enabled flag");

  a_sysen_gates: assert property (!ctrl_q[CTRL_SYSEN] |=> !usb_irq_o) // [RL15]
    else $error("interrupt raised while system enable off");

  a_resume_gated: assert property ($rose(cm_flags_q[BIT_RSU]) |-> $past(suspend_q)) // [RL10]
    else $error("resume flag set outside suspend mode");

  a_suspend_gated: assert property ( // [RL11]
    $rose(cm_flags_q[BIT_SUS]) |-> $past(ctrl_q[CTRL_SUSPEND_DETECT_ENABLE]))
    else $error("suspend flag set with detection off");

  a_bus_reset_en: assert property ( // [RL17]
    evt_i.bus_reset |=> in_en_q == IN_MASK && out_en_q == OUT_MASK &&
      cm_flags_q[BIT_RST] && (cm_en_q & CM_BUS_RST_EN) == CM_BUS_RST_EN)
    else $error("bus reset did not enable sources");

  a_frame_latch: assert property (evt_i.sof_valid |=> frame_q == $past(frame_num_i)) // [RL18]
    else $error("frame number not latched");

  a_sof_synth: assert property (sof_synth |=> cm_flags_q[BIT_SOF] && fcnt_q == '0) // [RL8]
    else $error("missed frame not synthesized");

  a_cm_unused_zero: assert property ( // [RL12] [RL7]
    cm_flags_q[7:4] == 4'h0 && out_flags_q[BIT_EP0] == 1'b0)
    else $error("unused flag bits set");

  a_ack_after_req: assert property (req |=> wb_ack_o)
    else $error("request not acknowledged in next cycle");

  a_read_clears_in: assert property (s_quiet_in_read |=> in_flags_q == 8'h00) // [RL4]
    else $error("IN flags not cleared by read");

  a_read_clears_out: assert property ( // [RL4]
    s_quiet_out_read |=> out_flags_q == 8'h00)
    else $error("OUT flags not cleared by read");

  a_read_returns_in: assert property ( // [RL4] [RL6]
    rd_req && idx == IDX_IN_FLAGS |=> wb_dat_o[7:0] == $past(in_flags_q))
    else $error("IN flag read data wrong");

  a_frame_lo_read: assert property ( // [RL1]
    rd_req && idx == IDX_FRAME_LO |=> wb_dat_o[7:0] == $past(frame_q[7:0]))
    else $error("frame low byte read wrong");

  a_frame_hi_read: assert property ( // [RL2]
    rd_req && idx == IDX_FRAME_HI |=> wb_dat_o[7:0] == {5'h00, $past(frame_q[10:8])})
    else $error("frame high byte read wrong");

  a_in_unused_zero: assert property (in_flags_q[7:2] == 6'h00) // [RL6]
    else $error("unused IN flag bits set");

  a_out_unused_zero: assert property (out_flags_q[7:2] == 6'h00) // [RL7]
    else $error("unused OUT flag bits set");

  a_en_reset_vals: assert property ( // [RL13] [RL14] [RL16]
    $fell(rst_i) |-> in_en_q == IN_EN_RST && out_en_q == OUT_EN_RST && cm_en_q == CM_EN_RST)
    else $error("enable reset values wrong");

  a_irq_needs_pending: assert property ( // [RL3] [RL15]
    usb_irq_o |-> $past(pending && ctrl_q[CTRL_SYSEN]))
    else $error("interrupt without enabled pending flag");

  a_out_evt_sets: assert property (evt_i.out_ep1 |=> out_flags_q[BIT_OUT_ENDPOINT_ONE_FLAG]) // [RL7] [RL19]
    else $error("OUT endpoint event lost");

  a_sof_flag_set: assert property (evt_i.sof_valid |=> cm_flags_q[BIT_SOF]) // [RL8]
    else $error("frame flag not set by token");

  a_suspend_sets: assert property ( // [RL11]
    evt_i.suspend && ctrl_q[CTRL_SUSPEND_DETECT_ENABLE] && !evt_i.resume && !evt_i.bus_reset |=>
      cm_flags_q[BIT_SUS] && suspend_q)
    else $error("suspend not entered");

  a_resume_sets: assert property ( // [RL10]
    evt_i.resume && suspend_q |=> cm_flags_q[BIT_RSU] && !suspend_q)
    else $error("resume in suspend mode not flagged");

  a_bus_reset_clears: assert property ( // [RL17]
    evt_i.bus_reset && !evt_i.ctrl_ep && !evt_i.in_ep1 && !evt_i.out_ep1 |=>
      in_flags_q == 8'h00 && out_flags_q == 8'h00)
    else $error("bus reset left endpoint flags set");

endmodule // ufi_regs
`default_nettype wire

// >>> ufi_evt_src.sv
`timescale 1ns/1ns
`default_nettype none
module ufi_evt_src (
  // Clock
  input wire logic clk_i,
  // Event strobes and frame number
  output var ufi_pkg::ufi_evt_t evt_o,
  output var logic [10:0] frame_o
);
  import ufi_pkg::*;
  // Idle at time zero
  initial begin
    evt_o = '0;
    frame_o = 11'h000;
  end
  // One-cycle strobe; frame bus is junk outside it
  task automatic fire(input logic [6:0] e, input logic [10:0] f);
    @(posedge clk_i);
    evt_o <= ufi_evt_t'(e);
    frame_o <= f;
    @(posedge clk_i);
    evt_o <= '0;
    frame_o <= ~f;
  endtask
endmodule // ufi_evt_src
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb;
  import ufi_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  // Bus master drive
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  // Design outputs
  logic ack, irq, smode;
  ufi_evt_t evt;
  logic [10:0] fnum, f;
  logic [7:0] v;
  int miscompares = 0, tests_run = 0, cyc_cnt = 0;
  logic [31:0] seed = 32'd99076;
  // Register addresses and reset values
  logic [7:0] ra [8] = '{8'h08, 8'h10, 8'h18, 8'h1C, 8'h24, 8'h2C, 8'h34, 8'h40};
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h02, 8'h06, 8'h00, 8'h00};
  // Endpoint flag places
  logic [7:0] fa [3] = '{8'h08, 8'h08, 8'h10};
  logic [7:0] fe [3] = '{8'h01, 8'h02, 8'h02};

  always #2 clk_i = ~clk_i;

  ufi_regs #(.FRAME_CYCLES_P(20)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .evt_i(evt), .frame_num_i(fnum),
    .usb_irq_o(irq), .suspend_mode_o(smode));
  ufi_evt_src ev_u (.clk_i(clk_i), .evt_o(evt), .frame_o(fnum));

  // Repeatable random source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Implemented bits of the enable registers by address
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h1C: return 8'h03;
      8'h24: return 8'h02;
      default: return 8'h0F;
    endcase
  endfunction
  // One classic cycle, waits for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    // The wait ends on ack; only the hang guard ends a wait whose ack never comes
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic crd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    `CHK(rd, {24'h0, e})
  endtask
  task automatic w3();
    repeat (3) @(posedge clk_i);
  endtask
  task automatic finish_test();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt > 20000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) crd(ra[i], rv[i]);
    crd(8'h3C, 8'h00);
    for (int i = 3; i < 6; i++) begin
      v = 8'(xs());
      wb(1'b1, ra[i], v);
      crd(ra[i], v & msk(ra[i]));
    end
    wb(1'b1, 8'h1C, 8'h03);
    wb(1'b1, 8'h24, 8'h02);
    // Write without the low byte select is ignored
    sel <= 4'hE;
    wb(1'b1, 8'h1C, 8'h00);
    sel <= 4'hF;
    crd(8'h1C, 8'h03);
    wb(1'b1, 8'h18, 8'hFF);
    crd(8'h18, 8'h00);
    // Endpoint flags: write ignored, read returns then clears
    for (int i = 0; i < 3; i++) begin
      ev_u.fire(7'h40 >> i, 11'h000);
      wb(1'b1, fa[i], 8'h00);
      crd(fa[i], fe[i]);
      crd(fa[i], 8'h00);
    end
    // Frame latch, then synthesized frames
    f = 11'(xs());
    ev_u.fire(7'h08, f);
    crd(8'h30, f[7:0]);
    crd(8'h34, {5'h00, f[10:8]});
    crd(8'h18, 8'h08);
    repeat (24) @(posedge clk_i);
    crd(8'h18, 8'h08);
    crd(8'h30, f[7:0]);
    // Bus reset turns enables on, suspend aside, and clears flags
    wb(1'b1, 8'h1C, 8'h00);
    wb(1'b1, 8'h2C, 8'h00);
    ev_u.fire(7'h40, 11'h000);
    ev_u.fire(7'h04, 11'h000);
    crd(8'h08, 8'h00);
    crd(8'h1C, 8'h03);
    crd(8'h2C, 8'h0E);
    crd(8'h18, 8'h04);
    // Suspend needs detection; resume needs suspend mode
    ev_u.fire(7'h01, 11'h000);
    ev_u.fire(7'h02, 11'h000);
    crd(8'h18, 8'h00);
    wb(1'b1, 8'h40, 8'h01);
    ev_u.fire(7'h01, 11'h000);
    @(posedge clk_i);
    `CHK(smode, 1'b1)
    crd(8'h44, 8'h01);
    ev_u.fire(7'h02, 11'h000);
    crd(8'h18, 8'h03);
    `CHK(smode, 1'b0)
    // Combined request and system gate
    wb(1'b1, 8'h1C, 8'h01);
    wb(1'b1, 8'h40, 8'h02);
    ev_u.fire(7'h20, 11'h000);
    w3();
    `CHK(irq, 1'b0)
    ev_u.fire(7'h40, 11'h000);
    w3();
    `CHK(irq, 1'b1)
    wb(1'b1, 8'h40, 8'h00);
    w3();
    `CHK(irq, 1'b0)
    wb(1'b1, 8'h40, 8'h02);
    w3();
    `CHK(irq, 1'b1)
    crd(8'h08, 8'h03);
    w3();
    `CHK(irq, 1'b0)
    // Event on the read edge survives
    fork
      ev_u.fire(7'h20, 11'h000);
      wb(1'b0, 8'h08, 8'h00);
    join
    `CHK(rd, 32'h0)
    crd(8'h08, 8'h02);
    finish_test();
  end
endmodule // tb
`default_nettype wire
